/* core/sig_pkg.sv */
// Constants, field layouts and carrier types for the signaling channel
// access block. Assumes a 25 MHz system clock and a register port of
// 4 address bits and 8 data bits.
//
// Contract
// (R1) Odd downstream slot of a set-up pair repeats the even location's value.
// (R2) Op 111X with read/write select 0 writes channel code and data.
// (R3) Op 1001 writes only the data field, code field stays as it was.
// (R4) Software formats 4-bit values as 11xxxx11 and 6-bit as xxxxxx11.
// (R5) 4-bit mode samples the odd upstream slot each frame into the even slot.
// (R6) Each 4-bit value change raises the flag and queues the even address.
// (R7) Valid queue entries carry a one in the top bit.
// (R8) 6/8-bit mode samples each frame or per timer period into the even slot.
// (R9) Stable value updates only on two equal samples differing from it.
// (R10) Stable value is kept at the odd location of the pair.
// (R11) Each stable value change raises the flag and queues the odd address.
// (R12) Rate select 1 samples every frame without the timer.
// (R13) Rate select 0 needs a started timer; no detection while it stands.
// (R14) Received values are ignored while the frame interface is idle.
// (R15) Matching preloaded values raise nothing; later changes raise and queue.
// (R16) Software reads status, queue, copies address, reads via op 1001.
// (R17) Queue holds 9 entries; further changes wait, none is lost.
// (R18) Flag clears only when the queue is empty, never on status read.
// (R19) Queue clear command empties queue and flag within 2 clocks.
// (R20) Timer period is (1 + 7-bit value) times 250 us.
// (R21) Reading an empty queue returns a byte with top bit zero.
package sig_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_MEM_DATA = 4'h0;
  localparam logic [3:0] OFS_MEM_ADDR = 4'h1;
  localparam logic [3:0] OFS_MEM_CMD = 4'h2;
  localparam logic [3:0] OFS_FIFO = 4'h3;
  localparam logic [3:0] OFS_TIMER = 4'h4;
  localparam logic [3:0] OFS_COMMAND = 4'h5;
  localparam logic [3:0] OFS_OPMODE = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int CMD_BIT_START = 0;
  localparam int CMD_BIT_CLEAR = 1;
  localparam int OPM_BIT_RUN = 6;
  localparam int IRQ_BIT_FIFO = 6;
  localparam int CODE_BIT_CS = 3;
  localparam logic [3:0] OP_DATA_ONLY = 4'h9;
  localparam logic [2:0] OP_CODE_DATA = 3'h7;
  localparam logic [1:0] MODE_CI4 = 2'h0;
  localparam logic [1:0] MODE_SIG6 = 2'h1;
  localparam logic [7:0] MASK_CI4 = 8'hC3;
  localparam logic [7:0] MASK_SIG6 = 8'h03;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CODE = 4'h0;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 9;
  localparam int FIFO_WIDTH = 8;
  localparam int CM_WORDS = 256;
  localparam int CLK_HZ = 25_000_000;
  localparam int TIMER_STEP_US = 250;
  localparam int TIMER_STEP_CYC = TIMER_STEP_US * (CLK_HZ / 1_000_000);
  localparam logic [12:0] RST_STEP = 13'h0000;
  localparam logic [6:0] RST_TICK = 7'h00;

  // Memory access engine states
  typedef enum logic [0:0] {
    MEM_IDLE = 1'b0,
    MEM_BUSY = 1'b1
  } mem_state_t;

  // Memory command register layout
  typedef struct packed {
    logic read_write_sel;
    logic [3:0] mem_op_code;
    logic [2:0] low;
  } mem_cmd_t;

  // One timeslot of the frame interface, upstream byte with it
  typedef struct packed {
    logic valid;
    logic [6:0] slot;
    logic [7:0] data;
  } ts_up_t;

  // Downstream byte for the timeslot strobed a cycle earlier
  typedef struct packed {
    logic valid;
    logic [6:0] slot;
    logic [7:0] data;
  } ts_dn_t;

endpackage : sig_pkg

/* core/change_addr_fifo.sv */
// Address queue for detected channel changes.
// Assumes the caller never pushes while full.
`timescale 1ns/10ps
`default_nettype none

module change_addr_fifo #(
  parameter int DEPTH = sig_pkg::FIFO_DEPTH,
  parameter int WIDTH = sig_pkg::FIFO_WIDTH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Control
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  input wire logic clear_in,
  // State
  output logic [WIDTH-1:0] head_out,
  output logic full_out,
  output logic empty_out
);

  localparam int PW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] FULL = PW'(DEPTH);
  localparam logic [PW-1:0] ZERO = '0;
  localparam logic [PW-1:0] ONE = PW'(1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] count;

  // Popping an empty queue is harmless; head reads as zero then
  wire logic do_pop = pop_in && !empty_out;
  wire logic do_push = push_in && !full_out;
  assign empty_out = (count == ZERO);
  assign full_out = (count == FULL);
  assign head_out = empty_out ? '0 : store[rd_ptr];

  // Pointer and count update; clear beats everything
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || clear_in) begin
      rd_ptr <= ZERO;
      wr_ptr <= ZERO;
      count <= ZERO;
    end else begin
      if (do_push) begin
        store[wr_ptr] <= push_data_in;
        wr_ptr <= (wr_ptr == LAST) ? ZERO : wr_ptr + ONE;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? ZERO : rd_ptr + ONE;
      end
      count <= count + (do_push ? ONE : ZERO) - (do_pop ? ONE : ZERO);
    end
  end

endmodule : change_addr_fifo

`default_nettype wire

/* core/signaling_channel_access.sv */
// Control/signaling channel access: control memory, downstream repeat,
// upstream sampling, double last look, change queue and sampling timer.
// Assumes one timeslot strobe per slot per frame, synchronous inputs.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module signaling_channel_access #(
  parameter int unsigned STEP_CYCLES = sig_pkg::TIMER_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Frame interface
  input wire logic frame_start_in,
  input wire sig_pkg::ts_up_t ts_up_in,
  output sig_pkg::ts_dn_t ts_dn_out,
  // Status
  output logic change_fifo_irq_out,
  output logic timer_active_out
);

  // ---------------------------------------------------------------
  // Storage and software registers
  // ---------------------------------------------------------------
  logic [3:0] cm_code [sig_pkg::CM_WORDS];
  logic [7:0] cm_data [sig_pkg::CM_WORDS];
  logic [7:0] mem_data_reg;
  logic [7:0] mem_addr_reg;
  sig_pkg::mem_cmd_t mem_cmd_reg;
  logic [7:0] timer_reg;
  logic [7:0] operation_mode_reg;
  sig_pkg::mem_state_t mem_state;
  logic timer_run;
  logic [12:0] step_cnt;
  logic [6:0] tick_cnt;
  logic sig_due;
  logic sig_frame;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire logic wr_data = reg_wr_in && reg_addr_in == sig_pkg::OFS_MEM_DATA;
  wire logic wr_addr = reg_wr_in && reg_addr_in == sig_pkg::OFS_MEM_ADDR;
  wire logic wr_cmd = reg_wr_in && reg_addr_in == sig_pkg::OFS_MEM_CMD;
  wire logic wr_timer = reg_wr_in && reg_addr_in == sig_pkg::OFS_TIMER;
  wire logic wr_command = reg_wr_in && reg_addr_in == sig_pkg::OFS_COMMAND;
  wire logic wr_opmode = reg_wr_in && reg_addr_in == sig_pkg::OFS_OPMODE;
  wire logic rd_fifo = reg_rd_in && reg_addr_in == sig_pkg::OFS_FIFO;
  wire logic start_cmd = wr_command && reg_wdata_in[sig_pkg::CMD_BIT_START];
  wire logic fifo_clear_cmd = wr_command &&
                              reg_wdata_in[sig_pkg::CMD_BIT_CLEAR];
  wire logic sampling_rate_sel = timer_reg[7];
  wire logic [6:0] timer_value = timer_reg[6:0];
  wire logic operational = operation_mode_reg[sig_pkg::OPM_BIT_RUN];
  wire logic mem_access_active = (mem_state == sig_pkg::MEM_BUSY);

  // ---------------------------------------------------------------
  // Memory access engine decode
  // ---------------------------------------------------------------
  // Frame traffic owns the memory in its cycle, so software waits then
  wire logic mem_go = mem_access_active && !ts_up_in.valid;
  wire logic op_code_data = !mem_cmd_reg.read_write_sel &&
      mem_cmd_reg.mem_op_code[3:1] == sig_pkg::OP_CODE_DATA;
  wire logic op_data_only = !mem_cmd_reg.read_write_sel &&
      mem_cmd_reg.mem_op_code == sig_pkg::OP_DATA_ONLY;
  wire logic op_read = mem_cmd_reg.read_write_sel &&
      mem_cmd_reg.mem_op_code == sig_pkg::OP_DATA_ONLY;
  wire logic [3:0] channel_code_bits = {mem_cmd_reg.mem_op_code[0],
                                        mem_cmd_reg.low};

  // ---------------------------------------------------------------
  // Downstream selection
  // ---------------------------------------------------------------
  wire logic [7:0] dn_ev = {1'b0, ts_up_in.slot[6:1], 1'b0};
  wire logic [7:0] dn_od = {1'b0, ts_up_in.slot};
  wire logic dn_pair = ts_up_in.slot[0] &&
      cm_code[dn_ev][sig_pkg::CODE_BIT_CS] &&
      cm_code[dn_od][sig_pkg::CODE_BIT_CS];
  // Odd slot of a pair repeats the even value every frame [R1]
  wire logic [7:0] dn_sel = dn_pair ? cm_data[dn_ev] : cm_data[dn_od];

  // ---------------------------------------------------------------
  // Upstream sampling and change detection
  // ---------------------------------------------------------------
  wire logic [7:0] up_ev = {1'b1, ts_up_in.slot[6:1], 1'b0};
  wire logic [7:0] up_od = {1'b1, ts_up_in.slot};
  wire logic [1:0] up_mode = cm_code[up_ev][2:1];
  wire logic up_ci = (up_mode == sig_pkg::MODE_CI4);
  wire logic up_pair = ts_up_in.slot[0] &&
      cm_code[up_ev][sig_pkg::CODE_BIT_CS] &&
      cm_code[up_od][sig_pkg::CODE_BIT_CS];
  // Unused bits forced to one so compares see only the payload
  wire logic [7:0] samp = up_ci ? (ts_up_in.data | sig_pkg::MASK_CI4) :
      (up_mode == sig_pkg::MODE_SIG6) ?
      (ts_up_in.data | sig_pkg::MASK_SIG6) : ts_up_in.data;
  // Idle interface ignored, so preloads survive activation [R14] [R15]
  wire logic up_take = ts_up_in.valid && operational && up_pair;
  wire logic ci_take = up_take && up_ci; // [R5]
  // Window latched under rate select 1 must not outlive a switch to timer
  wire logic sig_take = up_take && !up_ci && sig_frame &&
                        (sampling_rate_sel || timer_run); // [R8] [R13]
  wire logic fifo_full;
  wire logic fifo_empty;
  wire logic [7:0] fifo_head;
  // Change with queue full is left pending at the line [R17]
  wire logic ci_change = ci_take && samp != cm_data[up_ev] && !fifo_full;
  // Two equal samples that differ from the stable value [R9]
  wire logic sig_change = sig_take && samp == cm_data[up_ev] &&
                          samp != cm_data[up_od] && !fifo_full;
  wire logic fifo_push = ci_change || sig_change; // [R6] [R11]
  // Top bit marks the entry valid and selects upstream [R7]
  wire logic [7:0] push_addr = ci_change ? up_ev : up_od;

  // ---------------------------------------------------------------
  // Timer decode
  // ---------------------------------------------------------------
  wire logic step_end = step_cnt == 13'(STEP_CYCLES - 1);
  wire logic tick_fire = timer_run && step_end &&
                         tick_cnt == timer_value; // [R20]
  // Stopped by a timer write or by leaving run mode
  wire logic next_run = (timer_run || start_cmd) && !wr_timer &&
      !(wr_opmode ? !reg_wdata_in[sig_pkg::OPM_BIT_RUN] : !operational);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr_in)
      sig_pkg::OFS_MEM_DATA: rd_mux = mem_data_reg;
      sig_pkg::OFS_MEM_ADDR: rd_mux = mem_addr_reg;
      sig_pkg::OFS_MEM_CMD: rd_mux = mem_cmd_reg;
      sig_pkg::OFS_FIFO: rd_mux = fifo_head; // [R21]
      sig_pkg::OFS_TIMER: rd_mux = timer_reg;
      sig_pkg::OFS_OPMODE: rd_mux = operation_mode_reg;
      sig_pkg::OFS_STATUS: rd_mux = {mem_access_active, timer_run, 6'h00};
      sig_pkg::OFS_IRQ_STATUS: rd_mux = {1'b0, !fifo_empty, 6'h00};
      default: rd_mux = sig_pkg::RST_BYTE;
    endcase
  end

  // ---------------------------------------------------------------
  // Change address queue
  // ---------------------------------------------------------------
  change_addr_fifo #(
    .DEPTH(sig_pkg::FIFO_DEPTH),
    .WIDTH(sig_pkg::FIFO_WIDTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .push_in(fifo_push),
    .push_data_in(push_addr),
    .pop_in(rd_fifo),
    .clear_in(fifo_clear_cmd), // [R19]
    .head_out(fifo_head),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );

  // ---------------------------------------------------------------
  // Software registers and memory engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mem_addr_reg <= sig_pkg::RST_BYTE;
      mem_cmd_reg <= sig_pkg::RST_BYTE;
      timer_reg <= sig_pkg::RST_BYTE;
      operation_mode_reg <= sig_pkg::RST_BYTE;
      mem_state <= sig_pkg::MEM_IDLE;
    end else begin
      if (wr_addr) mem_addr_reg <= reg_wdata_in;
      if (wr_timer) timer_reg <= reg_wdata_in;
      if (wr_opmode) operation_mode_reg <= reg_wdata_in;
      // Command taken only while idle; a busy write is dropped
      if (wr_cmd && !mem_access_active) begin
        mem_cmd_reg <= reg_wdata_in;
        mem_state <= sig_pkg::MEM_BUSY;
      end else if (mem_go) begin
        mem_state <= sig_pkg::MEM_IDLE;
      end
    end
  end

  // Data register: software write or memory read-back
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mem_data_reg <= sig_pkg::RST_BYTE;
    end else if (mem_go && op_read) begin
      mem_data_reg <= cm_data[mem_addr_reg];
    end else if (wr_data && !mem_access_active) begin
      mem_data_reg <= reg_wdata_in;
    end
  end

  // Control memory; codes reset so no slot looks set up at start
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < sig_pkg::CM_WORDS; i++) begin
        cm_code[i] <= sig_pkg::RST_CODE;
      end
    end else if (mem_go && op_code_data) begin
      cm_code[mem_addr_reg] <= channel_code_bits; // [R2]
      cm_data[mem_addr_reg] <= mem_data_reg; // [R2]
    end else if (mem_go && op_data_only) begin
      cm_data[mem_addr_reg] <= mem_data_reg; // [R3]
    end else begin
      if (ci_change || sig_take) cm_data[up_ev] <= samp; // [R5] [R8]
      if (sig_change) cm_data[up_od] <= samp; // [R10]
    end
  end

  // ---------------------------------------------------------------
  // Sampling timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || !timer_run) begin
      step_cnt <= sig_pkg::RST_STEP;
      tick_cnt <= sig_pkg::RST_TICK;
    end else if (step_end) begin
      step_cnt <= sig_pkg::RST_STEP;
      tick_cnt <= tick_fire ? sig_pkg::RST_TICK : tick_cnt + 7'h01;
    end else begin
      step_cnt <= step_cnt + 13'h0001;
    end
  end

  // Sample window latched at frame start; expiry set beats clear
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      timer_run <= 1'b0;
      sig_due <= 1'b0;
      sig_frame <= 1'b0;
    end else begin
      timer_run <= next_run;
      sig_due <= tick_fire || (sig_due && !frame_start_in);
      if (frame_start_in) begin
        sig_frame <= sampling_rate_sel || sig_due; // [R12] [R13]
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= sig_pkg::RST_BYTE;
      ts_dn_out <= '0;
      change_fifo_irq_out <= 1'b0;
      timer_active_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : sig_pkg::RST_BYTE;
      ts_dn_out <= {ts_up_in.valid, ts_up_in.slot, dn_sel};
      change_fifo_irq_out <= !fifo_empty; // [R18]
      timer_active_out <= timer_run;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_dn_repeat;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ts_up_in.valid && dn_pair |=>
      ts_dn_out.data == cm_data[{1'b0, ts_dn_out.slot[6:1], 1'b0}];
  endproperty
  a_dn_repeat: assert property (p_dn_repeat) // [R1]
    else $error("odd slot not repeating even value");

  property p_code_write;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    mem_go && op_code_data |=>
      cm_code[$past(mem_addr_reg)] == $past(channel_code_bits) &&
      cm_data[$past(mem_addr_reg)] == $past(mem_data_reg) &&
      !mem_access_active;
  endproperty
  a_code_write: assert property (p_code_write) // [R2]
    else $error("code and data write failed");

  property p_data_write;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    mem_go && op_data_only |=>
      cm_data[$past(mem_addr_reg)] == $past(mem_data_reg) &&
      cm_code[$past(mem_addr_reg)] == $past(cm_code[mem_addr_reg]);
  endproperty
  a_data_write: assert property (p_data_write) // [R3]
    else $error("data only write wrong");

  property p_entry_valid;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fifo_push |=> ##[0:20] !fifo_empty && fifo_head[7];
  endproperty
  a_entry_valid: assert property (p_entry_valid) // [R7]
    else $error("queue entry without valid bit");

  property p_empty_read;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    rd_fifo && fifo_empty |=> reg_rdata_out[7] == 1'b0;
  endproperty
  a_empty_read: assert property (p_empty_read) // [R21]
    else $error("empty queue read shows valid bit");

  property p_clear;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fifo_clear_cmd |=> ##1 !change_fifo_irq_out;
  endproperty
  a_clear: assert property (p_clear) // [R19]
    else $error("flag not cleared by queue clear");

  property p_flag_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(change_fifo_irq_out) |-> $past(fifo_empty);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // [R18]
    else $error("flag fell with entries left");

  property p_idle_ignore;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !operational |-> !fifo_push;
  endproperty
  a_idle_ignore: assert property (p_idle_ignore) // [R14]
    else $error("change taken while interface idle");

  property p_timer_gate;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    sig_change |-> sig_frame && $past(sampling_rate_sel || timer_run, 1);
  endproperty
  a_timer_gate: assert property (p_timer_gate) // [R13]
    else $error("signaling change without sample window");

  property p_double_look;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    sig_change |=> cm_data[$past(up_od)] == cm_data[$past(up_ev)];
  endproperty
  a_double_look: assert property (p_double_look) // [R9]
    else $error("stable value not equal to last samples");

endmodule : signaling_channel_access

`default_nettype wire

/* verification/subscriber_model.sv */
// Subscriber circuit model: frame strobes, upstream slot bytes and a
// record of downstream bytes. Assumes the bench edits up_val directly.
`timescale 1ns/10ps
`default_nettype none

module subscriber_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Frame interface
  input wire sig_pkg::ts_dn_t ts_dn_in,
  output logic frame_start_out,
  output sig_pkg::ts_up_t ts_up_out
);
  logic [7:0] up_val [8];
  logic [7:0] dn_val [8];
  logic [5:0] cyc = 6'h00;

  // Quiet lines until reset ends
  initial begin
    frame_start_out = 1'b0;
    ts_up_out = '0;
    for (int i = 0; i < 8; i++) begin
      up_val[i] = 8'hFF;
      dn_val[i] = 8'h00;
    end
  end

  // 40-cycle frame, slot k strobed 4k+2 cycles after frame start
  always @(posedge clk_sys_in) begin
    cyc <= (!nrst_in || cyc == 6'h27) ? 6'h00 : cyc + 6'h01;
    frame_start_out <= nrst_in && cyc == 6'h27;
    ts_up_out.valid <= nrst_in && cyc[1:0] == 2'h1 && cyc < 6'h20;
    ts_up_out.slot <= {4'h0, cyc[4:2]};
    // Off-slot data toggles, so a stale byte never passes as fresh
    ts_up_out.data <= cyc[1:0] == 2'h1 ? up_val[cyc[4:2]] : ~ts_up_out.data;
    if (ts_dn_in.valid)
      dn_val[ts_dn_in.slot[2:0]] <= ts_dn_in.data;
  end
endmodule : subscriber_model
`default_nettype wire

/* verification/signaling_channel_access_tb.sv */
// Self-checking bench: register port tasks, one task per scenario.
// Assumes the subscriber model makes frames of 40 cycles.
`timescale 1ns/10ps
`default_nettype none

module signaling_channel_access_tb;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic frame_start_in;
  sig_pkg::ts_up_t ts_up_in;
  sig_pkg::ts_dn_t ts_dn_out;
  logic change_fifo_irq_out;
  logic timer_active_out;
  logic [7:0] rd;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  // Short timer step keeps timed sampling inside one frame
  signaling_channel_access #(.STEP_CYCLES(4)) signaling_channel_access_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .frame_start_in(frame_start_in),
    .ts_up_in(ts_up_in), .ts_dn_out(ts_dn_out),
    .change_fifo_irq_out(change_fifo_irq_out),
    .timer_active_out(timer_active_out));

  subscriber_model subscriber_model_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ts_dn_in(ts_dn_out),
    .frame_start_out(frame_start_in), .ts_up_out(ts_up_in));

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  always #20 clk_sys_in = ~clk_sys_in;

  // Whole run needs about 1750 cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Strobe for one edge, then one idle edge before the next strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    rd = reg_rdata_out;
    @(posedge clk_sys_in);
  endtask : rdr

  // Indirect memory access, polled until the access engine is idle
  task automatic mem(input logic [7:0] a, input logic [7:0] c,
                     input logic [7:0] d);
    int n;
    n = 0;
    wr(sig_pkg::OFS_MEM_DATA, d);
    wr(sig_pkg::OFS_MEM_ADDR, a);
    wr(sig_pkg::OFS_MEM_CMD, c);
    rdr(sig_pkg::OFS_STATUS);
    while (rd[7] !== 1'b0 && n < 50) begin
      rdr(sig_pkg::OFS_STATUS);
      n++;
    end
    chk(rd & 8'h80, 8'h00);
  endtask : mem

  task automatic frames(input int n);
    repeat (n) @(posedge clk_sys_in iff frame_start_in);
  endtask : frames

  task automatic irq(input logic exp);
    @(negedge clk_sys_in);
    chk({7'h00, change_fifo_irq_out}, {7'h00, exp});
    @(posedge clk_sys_in);
  endtask : irq

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_down();
    mem(8'h06, 8'h7A, 8'h57);
    mem(8'h07, 8'h7B, 8'hFF);
    frames(2);
    chk(subscriber_model_inst.dn_val[7], 8'h57);
    mem(8'h06, 8'h48, 8'hCF);
    frames(2);
    chk(subscriber_model_inst.dn_val[7], 8'hCF);
    $display("done downstream");
  endtask : t_down

  // Preload while idle, a differing line must stay silent
  task automatic t_idle();
    subscriber_model_inst.up_val[5] <= 8'hC3;
    subscriber_model_inst.up_val[7] <= 8'h33;
    mem(8'h84, 8'h78, 8'hC3);
    mem(8'h85, 8'h78, 8'hFF);
    mem(8'h86, 8'h7A, 8'h77);
    mem(8'h87, 8'h7A, 8'h77);
    wr(sig_pkg::OFS_TIMER, 8'h80);
    frames(3);
    irq(1'b0);
    subscriber_model_inst.up_val[7] <= 8'h77;
    wr(sig_pkg::OFS_OPMODE, 8'h40);
    frames(3);
    irq(1'b0);
    $display("done preload");
  endtask : t_idle

  task automatic t_sig();
    subscriber_model_inst.up_val[7] <= 8'h13;
    frames(1);
    subscriber_model_inst.up_val[7] <= 8'h77;
    frames(3);
    irq(1'b0);
    subscriber_model_inst.up_val[7] <= 8'h33;
    frames(3);
    irq(1'b1);
    rdr(sig_pkg::OFS_IRQ_STATUS);
    rdr(sig_pkg::OFS_IRQ_STATUS);
    chk(rd, 8'h40);
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h87);
    mem(8'h87, 8'hC8, 8'h00);
    rdr(sig_pkg::OFS_MEM_DATA);
    chk(rd, 8'h33);
    mem(8'h86, 8'hC8, 8'h00);
    rdr(sig_pkg::OFS_MEM_DATA);
    chk(rd, 8'h33);
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h00);
    irq(1'b0);
    $display("done signaling");
  endtask : t_sig

  task automatic t_ci();
    subscriber_model_inst.up_val[5] <= 8'hC7;
    frames(2);
    irq(1'b1);
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h84);
    mem(8'h84, 8'hC8, 8'h00);
    rdr(sig_pkg::OFS_MEM_DATA);
    chk(rd, 8'hC7);
    $display("done command indication");
  endtask : t_ci

  // Two queued entries, then the clear command
  task automatic t_clear();
    subscriber_model_inst.up_val[5] <= 8'hC3;
    subscriber_model_inst.up_val[7] <= 8'h77;
    frames(3);
    irq(1'b1);
    wr(sig_pkg::OFS_COMMAND, 8'h02);
    irq(1'b0);
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h00);
    $display("done queue clear");
  endtask : t_clear

  // Timed sampling stays silent until the timer is started
  task automatic t_timer();
    wr(sig_pkg::OFS_TIMER, 8'h00);
    subscriber_model_inst.up_val[7] <= 8'h33;
    frames(3);
    irq(1'b0);
    wr(sig_pkg::OFS_COMMAND, 8'h01);
    rdr(sig_pkg::OFS_STATUS);
    chk(rd & 8'h40, 8'h40);
    @(negedge clk_sys_in);
    chk({7'h00, timer_active_out}, 8'h01);
    frames(4);
    irq(1'b1);
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h87);
    $display("done timer");
  endtask : t_timer

  // Ten C/I changes against the nine-entry queue; the last one waits
  task automatic t_full();
    frames(1);
    for (int i = 0; i < 10; i++) begin
      subscriber_model_inst.up_val[5] <= i[0] ? 8'hC3 : 8'hC7;
      frames(1);
    end
    mem(8'h84, 8'hC8, 8'h00);
    rdr(sig_pkg::OFS_MEM_DATA);
    chk(rd, 8'hC7);
    rdr(sig_pkg::OFS_FIFO);
    frames(2);
    repeat (9) begin
      rdr(sig_pkg::OFS_FIFO);
      chk(rd, 8'h84);
    end
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h00);
    mem(8'h84, 8'hC8, 8'h00);
    rdr(sig_pkg::OFS_MEM_DATA);
    chk(rd, 8'hC3);
    $display("done queue full");
  endtask : t_full

  initial begin
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    irq(1'b0);
    rdr(sig_pkg::OFS_FIFO);
    chk(rd, 8'h00);
    t_down();
    t_idle();
    t_sig();
    t_ci();
    t_clear();
    t_timer();
    t_full();
    final_report();
  end
endmodule : signaling_channel_access_tb
`default_nettype wire
